/* src/upfp_port.sv */
`timescale 1ns/1ps
// Parallel FIFO handshake port with power and reset control
module upfp_port import upfp_pkg::*; #(
    parameter int unsigned CLR_DELAY_CYC = UPFP_CLR_DELAY_CYC,
    parameter int unsigned GAP_CYC = UPFP_FLAG_GAP_CYC
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Pin side
    input wire logic rd_strobe_n_i,
    input wire logic wr_strobe_i,
    input wire logic [UPFP_DATA_W-1:0] data_i,
    output logic [UPFP_DATA_W-1:0] data_o,
    output logic data_oe_n_o,
    output logic tx_space_n_o,
    output logic tx_space_oe_n_o,
    output logic rx_avail_n_o,
    output logic rx_avail_oe_n_o,
    output logic power_enable_n_o,
    input wire logic send_now_wake_n_i,
    output logic chained_clear_out_n_o,
    output logic chained_clear_oe_n_o,
    input wire logic prom_select_i,
    input wire logic prom_clock_i,
    output logic osc_run_o,
    output logic pins_pull_low_o,
    output logic clk_48m_sel_o,
    output logic alt_product_o,
    // Core side
    input wire logic usb_configured_i,
    input wire logic usb_suspend_i,
    input wire logic remote_wake_en_i,
    input wire logic pull_down_opt_i,
    input wire logic [UPFP_DATA_W-1:0] rx_byte_i,
    input wire logic rx_valid_i,
    output logic rx_pop_o,
    output logic [UPFP_DATA_W-1:0] tx_byte_o,
    output logic tx_push_o,
    input wire logic tx_full_i,
    output logic resume_req_o,
    output logic flush_req_o
);
    logic rd_s, wr_s, wake_s, rd_q, wr_q, wake_q;
    logic rd_rise, wr_fall, wake_fall;
    logic [UPFP_GAP_W-1:0] rx_gap_q, tx_gap_q;
    logic [UPFP_CLR_W-1:0] clr_cnt_q;
    logic [UPFP_DATA_W-1:0] data_d;
    logic straps_done_q;
    logic [1:0] strap_age_q;
    logic [UPFP_DATA_W-1:0] data_meta_q, data_s_q;
    logic prom_sel_s, prom_clk_s;
    upfp_pwr_t pwr_q;

    upfp_sync #(.RST_VAL(1'b1)) u_rd (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .async_i(rd_strobe_n_i), .sync_o(rd_s));
    upfp_sync #(.RST_VAL(1'b0)) u_wr (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .async_i(wr_strobe_i), .sync_o(wr_s));
    upfp_sync #(.RST_VAL(1'b1)) u_wk (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .async_i(send_now_wake_n_i), .sync_o(wake_s));
    // Strap synchronisers, idle high as with no resistor fitted
    upfp_sync #(.RST_VAL(1'b1)) u_sel (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .async_i(prom_select_i), .sync_o(prom_sel_s));
    upfp_sync #(.RST_VAL(1'b1)) u_sck (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .async_i(prom_clock_i), .sync_o(prom_clk_s));

    // Delayed copies for edge detection
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_q <= 1'b1;
            wr_q <= 1'b0;
            wake_q <= 1'b1;
        end else begin
            rd_q <= rd_s;
            wr_q <= wr_s;
            wake_q <= wake_s;
        end
    end

    assign rd_rise = rd_s & ~rd_q;
    assign wr_fall = ~wr_s & wr_q;
    assign wake_fall = ~wake_s & wake_q;

    // Power state tracking
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pwr_q <= UPFP_ST_RESET;
        end else begin
            case (pwr_q)
                UPFP_ST_RESET: begin
                    if (usb_configured_i) begin
                        pwr_q <= UPFP_ST_ACTIVE;
                    end
                end
                UPFP_ST_ACTIVE: begin
                    if (!usb_configured_i) begin
                        pwr_q <= UPFP_ST_RESET;
                    end else if (usb_suspend_i) begin
                        pwr_q <= UPFP_ST_SUSPEND;
                    end
                end
                UPFP_ST_SUSPEND: begin
                    if (!usb_suspend_i) begin
                        pwr_q <= usb_configured_i ? UPFP_ST_ACTIVE : UPFP_ST_RESET;
                    end
                end
                default: pwr_q <= UPFP_ST_RESET;
            endcase
        end
    end

    // power enable, oscillator gate, pull selection
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            power_enable_n_o <= 1'b1;
            osc_run_o <= 1'b1;
            pins_pull_low_o <= 1'b0;
        end else begin
            power_enable_n_o <= (pwr_q != UPFP_ST_ACTIVE);
            osc_run_o <= (pwr_q != UPFP_ST_SUSPEND);
            pins_pull_low_o <= (pwr_q == UPFP_ST_SUSPEND) & pull_down_opt_i;
        end
    end

    // resume and flush requests, one-cycle pulses
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            resume_req_o <= 1'b0;
            flush_req_o <= 1'b0;
        end else begin
            resume_req_o <= wake_fall & power_enable_n_o & (pwr_q == UPFP_ST_SUSPEND) & remote_wake_en_i;
            flush_req_o <= wake_fall & ~power_enable_n_o;
        end
    end

    // data drive while read strobe low
    always_comb begin
        data_d = data_o;
        if (rd_s) begin
            data_d = rx_byte_i;
        end
    end
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            data_o <= '0;
            data_oe_n_o <= 1'b1;
        end else begin
            data_o <= data_d;
            data_oe_n_o <= rd_s;
        end
    end

    // Bus word double flop; the word is stable long before the write fall is seen
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            data_meta_q <= '0;
            data_s_q <= '0;
        end else begin
            data_meta_q <= data_i;
            data_s_q <= data_meta_q;
        end
    end

    // pop and push toward the core buffers
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_pop_o <= 1'b0;
            tx_push_o <= 1'b0;
            tx_byte_o <= '0;
        end else begin
            rx_pop_o <= rd_rise & rx_valid_i;
            tx_push_o <= wr_fall & ~tx_full_i;
            if (wr_fall) begin
                tx_byte_o <= data_s_q;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_gap_q <= '0;
            tx_gap_q <= '0;
        end else begin
            if (rd_rise) begin
                rx_gap_q <= UPFP_GAP_W'(GAP_CYC);
            end else if (rx_gap_q != '0) begin
                rx_gap_q <= rx_gap_q - 1'b1;
            end
            if (wr_fall) begin
                tx_gap_q <= UPFP_GAP_W'(GAP_CYC);
            end else if (tx_gap_q != '0) begin
                tx_gap_q <= tx_gap_q - 1'b1;
            end
        end
    end

    // receive flag, space flag, float in reset
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_avail_n_o <= 1'b1;
            tx_space_n_o <= 1'b1;
            rx_avail_oe_n_o <= 1'b1;
            tx_space_oe_n_o <= 1'b1;
        end else begin
            rx_avail_n_o <= ~rx_valid_i | rd_rise | (rx_gap_q != '0) | ~rd_s;
            tx_space_n_o <= tx_full_i | wr_fall | (tx_gap_q != '0) | wr_s;
            rx_avail_oe_n_o <= 1'b0;
            tx_space_oe_n_o <= 1'b0;
        end
    end

    // chained clear: low in reset, float, then high
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clr_cnt_q <= '0;
            chained_clear_out_n_o <= 1'b0;
            chained_clear_oe_n_o <= 1'b0;
        end else if (clr_cnt_q < UPFP_CLR_W'(CLR_DELAY_CYC)) begin
            clr_cnt_q <= clr_cnt_q + 1'b1;
            chained_clear_oe_n_o <= 1'b1;
        end else begin
            chained_clear_out_n_o <= 1'b1;
            chained_clear_oe_n_o <= 1'b0;
        end
    end

    // strap capture once the synchronisers hold real pin levels
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            strap_age_q <= '0;
            straps_done_q <= 1'b0;
            clk_48m_sel_o <= 1'b0;
            alt_product_o <= 1'b0;
        end else begin
            strap_age_q <= {strap_age_q[0], 1'b1};
            if (strap_age_q[1] && !straps_done_q) begin
                straps_done_q <= 1'b1;
                clk_48m_sel_o <= ~prom_sel_s;
                alt_product_o <= ~prom_clk_s;
            end
        end
    end

    chk_rx_gap_hold: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        rd_rise |=> rx_avail_n_o [*2]) else $error("rx flag reasserted too soon");
    chk_tx_gap_hold: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        wr_fall |=> tx_space_n_o [*2]) else $error("tx flag reasserted too soon");
    chk_rd_drive: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        !rd_s |=> !data_oe_n_o && $stable(data_o)) else $error("data not driven steadily during read");
    chk_wr_capture: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        wr_fall |=> tx_byte_o == $past(data_s_q)) else $error("write byte not captured");
    chk_rd_pop: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        rd_rise && rx_valid_i |=> rx_pop_o) else $error("no pop after read");
    chk_pwr_suspend: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        pwr_q == UPFP_ST_SUSPEND |=> power_enable_n_o) else $error("power enable low in suspend");
    chk_flush_active: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        flush_req_o |-> $past(!power_enable_n_o)) else $error("flush while powered off");
    chk_osc_stop: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        pwr_q == UPFP_ST_SUSPEND |=> !osc_run_o) else $error("oscillator running in suspend");
    cov_read: cover property (@(posedge core_clk_i) disable iff (!nrst_i) rx_pop_o);
    cov_write: cover property (@(posedge core_clk_i) disable iff (!nrst_i) tx_push_o);
    cov_resume: cover property (@(posedge core_clk_i) disable iff (!nrst_i) resume_req_o);
    cov_flush: cover property (@(posedge core_clk_i) disable iff (!nrst_i) flush_req_o);
endmodule

/* inc/upfp_pkg.sv */
package upfp_pkg;
    localparam int unsigned UPFP_CLK_HZ = 10000000;
    localparam int unsigned UPFP_DATA_W = 8;
    // Flag recovery time in ns after a strobe cycle
    localparam int unsigned UPFP_FLAG_GAP_NS = 80;
    localparam int unsigned UPFP_FLAG_GAP_CYC_RAW =
        (UPFP_FLAG_GAP_NS * (UPFP_CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned UPFP_FLAG_GAP_CYC =
        (UPFP_FLAG_GAP_CYC_RAW < 1) ? 1 : UPFP_FLAG_GAP_CYC_RAW;
    // Chained clear release delay in ms
    localparam int unsigned UPFP_CLR_DELAY_MS = 5;
    localparam int unsigned UPFP_CLR_DELAY_CYC = UPFP_CLR_DELAY_MS * (UPFP_CLK_HZ / 1000);
    localparam int unsigned UPFP_GAP_W = 4;
    localparam int unsigned UPFP_CLR_W = 20;
    typedef enum logic [2:0] {
        UPFP_ST_RESET = 3'h1,
        UPFP_ST_ACTIVE = 3'h2,
        UPFP_ST_SUSPEND = 3'h4
    } upfp_pwr_t;
endpackage

/* src/upfp_sync.sv */
`timescale 1ns/1ps
// Two-flop synchroniser with a set value at reset
module upfp_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic async_i,
    output logic sync_o
);
    logic meta_q;
    // Double flop for metastability
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

/* tb/upfp_host_model.sv */
`timescale 1ns/1ps
// Controller on the far side of the handshake port
module upfp_host_model (
    input wire logic core_clk_i,
    input wire logic rx_avail_n_i,
    input wire logic tx_space_n_i,
    input wire logic [7:0] bus_i,
    output logic rd_strobe_n_o,
    output logic wr_strobe_o,
    output logic [7:0] data_o
);
    // Idle strobes, data output parked at 5A
    initial begin
        rd_strobe_n_o = 1'b1;
        wr_strobe_o = 1'b0;
        data_o = 8'h5A;
    end
    // Bounded wait on a flag, 1 selects space
    task automatic wait_low(input logic which, output bit ok);
        ok = 1'b0;
        for (int i = 0; i < 200 && !ok; i++) begin
            @(posedge core_clk_i);
            ok = which ? (tx_space_n_i === 1'b0) : (rx_avail_n_i === 1'b0);
        end
    endtask
    task automatic do_read(output logic [7:0] b, output bit ok);
        wait_low(1'b0, ok);
        if (ok) begin
            rd_strobe_n_o <= 1'b0;
            repeat (4) @(posedge core_clk_i);
            b = bus_i;
            rd_strobe_n_o <= 1'b1;
            repeat (5) @(posedge core_clk_i);
        end
    endtask
    task automatic do_write(input logic [7:0] b, output bit ok);
        wait_low(1'b1, ok);
        if (ok) begin
            data_o <= b;
            wr_strobe_o <= 1'b1;
            repeat (3) @(posedge core_clk_i);
            wr_strobe_o <= 1'b0;
            repeat (4) @(posedge core_clk_i);
            data_o <= ~b;
            repeat (3) @(posedge core_clk_i);
        end
    endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench for the handshake port
module tb_top import upfp_pkg::*;;
    localparam int unsigned CLR_SIM = 20;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic rd_n, wr, send_n = 1'b1, cfg = 1'b0, susp = 1'b0, rwake = 1'b0, pdo = 1'b0, tx_full = 1'b0;
    logic [7:0] host_d, dev_d, bus, rx_byte = 8'h00, tx_byte;
    logic rx_valid = 1'b0;
    logic strap_sel = 1'b0, strap_clk = 1'b1;
    logic data_oe_n, txs_n, txs_oe_n, rxa_n, rxa_oe_n, pwr_n, clr_n, clr_oe_n, osc_run, pull_low, sel48, alt;
    logic rx_pop, tx_push, resume, flush;
    logic [7:0] rxq[$], erx[$], txq[$], etx[$];
    int num_errors = 0;
    int total_checks = 0;
    integer seed = 32'h5680458a;
    always #50 core_clk = ~core_clk;
    assign bus = (data_oe_n === 1'b0) ? dev_d : host_d;
    // factory test pin not brought out, so it stays inactive
    upfp_port #(.CLR_DELAY_CYC(CLR_SIM), .GAP_CYC(UPFP_FLAG_GAP_CYC)) upfp_port_inst (
        .core_clk_i(core_clk), .nrst_i(nrst), .rd_strobe_n_i(rd_n), .wr_strobe_i(wr), .data_i(bus),
        .data_o(dev_d), .data_oe_n_o(data_oe_n), .tx_space_n_o(txs_n), .tx_space_oe_n_o(txs_oe_n),
        .rx_avail_n_o(rxa_n), .rx_avail_oe_n_o(rxa_oe_n), .power_enable_n_o(pwr_n),
        .send_now_wake_n_i(send_n), .chained_clear_out_n_o(clr_n), .chained_clear_oe_n_o(clr_oe_n),
        .prom_select_i(strap_sel), .prom_clock_i(strap_clk), .osc_run_o(osc_run), .pins_pull_low_o(pull_low),
        .clk_48m_sel_o(sel48), .alt_product_o(alt), .usb_configured_i(cfg), .usb_suspend_i(susp),
        .remote_wake_en_i(rwake), .pull_down_opt_i(pdo), .rx_byte_i(rx_byte), .rx_valid_i(rx_valid),
        .rx_pop_o(rx_pop), .tx_byte_o(tx_byte), .tx_push_o(tx_push), .tx_full_i(tx_full),
        .resume_req_o(resume), .flush_req_o(flush));
    upfp_host_model upfp_host_model_inst (.core_clk_i(core_clk), .rx_avail_n_i(rxa_n), .tx_space_n_i(txs_n),
        .bus_i(bus), .rd_strobe_n_o(rd_n), .wr_strobe_o(wr), .data_o(host_d));
    // Core-side receive store and transmit sink
    always @(posedge core_clk) begin
        if (rx_pop === 1'b1) void'(rxq.pop_front());
        rx_valid <= (rxq.size() != 0);
        rx_byte <= (rxq.size() != 0) ? rxq[0] : 8'h00;
        if (tx_push === 1'b1) txq.push_back(tx_byte);
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Bounded wait for a pulse, 0 flush, 1 resume
    task automatic wait_for(input int which);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 40 && !seen; i++) begin
            @(posedge core_clk);
            seen = (((which == 0) ? flush : resume) === 1'b1);
        end
        check((which == 0) ? "flush_pulse" : "resume_pulse", {7'h00, seen}, 8'h01);
        if (!seen) give_verdict();
    endtask
    task automatic bail(input bit ok);
        check("flag_wait", {7'h00, ok}, 8'h01);
        if (!ok) give_verdict();
    endtask
    // Main sequence
    initial begin
        logic [7:0] b;
        bit ok;
        int n;
        repeat (12) @(posedge core_clk);
        check("clear_n", {7'h00, clr_n}, 8'h00);
        check("flag_oe", {6'h00, txs_oe_n, rxa_oe_n}, 8'h03);
        nrst <= 1'b1;
        repeat (2) @(posedge core_clk);
        check("clear_float", {7'h00, clr_oe_n}, 8'h01);
        repeat (CLR_SIM + 4) @(posedge core_clk);
        check("clear_high", {6'h00, clr_oe_n, clr_n}, 8'h01);
        check("sel48", {7'h00, sel48}, 8'h01);
        check("alt_pid", {7'h00, alt}, 8'h00);
        $display("reset test done");
        cfg <= 1'b1;
        repeat (4) @(posedge core_clk);
        check("pwr_n", {7'h00, pwr_n}, 8'h00);
        n = 3 + ($unsigned($random(seed)) % 4);
        for (int i = 0; i < n; i++) begin
            b = (i == 0) ? 8'hFF : 8'($random(seed));
            rxq.push_back(b);
            erx.push_back(b);
        end
        for (int i = 0; i < n; i++) begin
            upfp_host_model_inst.do_read(b, ok);
            bail(ok);
            check("rd_byte", b, erx[i]);
        end
        repeat (4) @(posedge core_clk);
        check("rx_left", 8'(rxq.size()), 8'h00);
        check("rx_flag", {7'h00, rxa_n}, 8'h01);
        $display("read test done");
        for (int i = 0; i < n; i++) begin
            b = (i == 0) ? 8'h00 : 8'($random(seed));
            etx.push_back(b);
            upfp_host_model_inst.do_write(b, ok);
            bail(ok);
        end
        repeat (4) @(posedge core_clk);
        check("tx_count", 8'(txq.size()), 8'(n));
        for (int i = 0; i < n && i < txq.size(); i++) check("tx_byte", txq[i], etx[i]);
        $display("write test done");
        // wake input idles high between pulses; watch starts with the pulse
        send_n <= 1'b0;
        wait_for(0);
        send_n <= 1'b1;
        susp <= 1'b1;
        pdo <= 1'b1;
        rwake <= 1'b1;
        repeat (5) @(posedge core_clk);
        check("pwr_susp", {7'h00, pwr_n}, 8'h01);
        check("osc_run", {7'h00, osc_run}, 8'h00);
        check("pull_low", {7'h00, pull_low}, 8'h01);
        send_n <= 1'b0;
        wait_for(1);
        send_n <= 1'b1;
        // Configuration lost as after a bus reset: chained clear must not move
        susp <= 1'b0;
        cfg <= 1'b0;
        repeat (4) @(posedge core_clk);
        check("pwr_unconf", {7'h00, pwr_n}, 8'h01);
        check("clear_busrst", {6'h00, clr_oe_n, clr_n}, 8'h01);
        $display("power test done");
        // Second reset with the opposite strap levels
        nrst <= 1'b0;
        strap_sel <= 1'b1;
        strap_clk <= 1'b0;
        repeat (2) @(posedge core_clk);
        check("clear_again", {6'h00, clr_oe_n, clr_n}, 8'h00);
        check("flag_oe_again", {6'h00, txs_oe_n, rxa_oe_n}, 8'h03);
        nrst <= 1'b1;
        repeat (2) @(posedge core_clk);
        check("clear_float_again", {7'h00, clr_oe_n}, 8'h01);
        repeat (4) @(posedge core_clk);
        check("sel6", {7'h00, sel48}, 8'h00);
        check("alt_pid_on", {7'h00, alt}, 8'h01);
        $display("reset again test done");
        give_verdict();
    end
endmodule
